// [hdl/fxa_pkg.sv]
// shared constants and types for the extended-address control block
package fxa_pkg;
  localparam logic [7:0] CMD_RD_SEG   = 8'h16;
  localparam logic [7:0] CMD_WR_SEG   = 8'h17;
  localparam logic [7:0] CMD_SOFT_RST = 8'hF0;
  localparam logic [7:0] CMD_WREN     = 8'h06;
  localparam logic [7:0] CMD_WRDI     = 8'h04;
  localparam logic [7:0] CMD_WRSR     = 8'h01;
  localparam logic [7:0] CMD_READ3    = 8'h03;
  localparam logic [7:0] CMD_READ4    = 8'h13;
  localparam int         SEG_MODE_BIT = 7;
  localparam logic [7:0] SEG_RST      = 8'h00;
  localparam int         SR_WIP_BIT   = 0;
  localparam int         SR_WEL_BIT   = 1;
  localparam int         SR_NV_LSB    = 2;
  localparam logic [5:0] SR_NV_RST    = 6'h00;
  localparam logic [2:0] ADDR_LEN3    = 3'h3;
  localparam logic [2:0] ADDR_LEN4    = 3'h4;
  localparam logic [2:0] SYNC_RST     = 3'h5;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  typedef enum logic [3:0] {
    ST_CMD  = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_SKIP = 4'b1000
  } fxa_state_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_WSEG = 3'h1,
    OP_WSR  = 3'h2,
    OP_WREN = 3'h3,
    OP_WRDI = 3'h4,
    OP_SRST = 3'h5
  } fxa_op_type;
endpackage

// [hdl/fxa_link_if.sv]
// carrier between the serial-clock front end and the control logic
`timescale 1ns/100ps
interface fxa_link_if;
  logic [7:0] rx_byte;
  logic       rx_tgl;
  logic       link_rst;
  logic [7:0] seg_mirror;
  modport link (output rx_byte, output rx_tgl, input link_rst, input seg_mirror);
  modport ctrl (input rx_byte, input rx_tgl, output link_rst, output seg_mirror);
endinterface

// [hdl/fxa_sync.sv]
// two-stage level synchroniser
`timescale 1ns/100ps
module fxa_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_r <= INIT;
      q      <= INIT;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// [hdl/fxa_link.sv]
// serial-clock front end: byte shifter and segment readback
`timescale 1ns/100ps
module fxa_link (
  input  wire logic spi_sck,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  output logic      spi_miso,
  output logic      spi_miso_oe,
  fxa_link_if.link  lif
);
  logic [2:0] bit_cnt_r;
  logic [6:0] sh_r;
  logic       first_r;
  logic       rd_go_r;
  logic       rd_seen_r;
  logic [7:0] tx_r;
  logic [7:0] byte_nxt;

  assign byte_nxt = {sh_r, spi_mosi};

  // frame state restarts with every deselect; the clock may stop between frames
  always_ff @(posedge spi_sck or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      bit_cnt_r <= 3'h0;
      sh_r      <= 7'h00;
      first_r   <= 1'b1;
      rd_go_r   <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r      <= byte_nxt[6:0];
      if (bit_cnt_r == fxa_pkg::BIT_LAST)
      begin
        first_r <= 1'b0;
        if (first_r && byte_nxt == fxa_pkg::CMD_RD_SEG)
          rd_go_r <= 1'b1;
      end
    end
  end

  // toggle and byte survive deselect so the last byte of a frame is not lost
  always_ff @(posedge spi_sck or posedge lif.link_rst)
  begin
    if (lif.link_rst)
    begin
      lif.rx_byte <= 8'h00;
      lif.rx_tgl  <= 1'b0;
    end
    else if (!spi_cs_n && bit_cnt_r == fxa_pkg::BIT_LAST)
    begin
      lif.rx_byte <= byte_nxt;
      lif.rx_tgl  <= ~lif.rx_tgl;
    end
  end

  // segment value is quiet during a frame: it only changes after a deselect, or on a hardware or system reset
  always_ff @(negedge spi_sck or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      tx_r      <= 8'h00;
      rd_seen_r <= 1'b0;
    end
    else
    begin
      rd_seen_r <= rd_go_r;
      if (rd_go_r && !rd_seen_r)
        tx_r <= lif.seg_mirror;
      else
        tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  assign spi_miso    = tx_r[7];
  assign spi_miso_oe = rd_seen_r && !spi_cs_n;
endmodule

// [hdl/fxa_ctrl.sv]
// extended-address control: segment register, status write gate and resets
`timescale 1ns/100ps
// Notes on behaviour
// - an 8-bit volatile segment register; low bits give A30..A24, bit 7 selects 4-byte mode.
// - with bit 7 set, every command takes 4 address bytes; segment bits ignored.
// - command 16h returns the current segment register contents.
// - command 17h plus exactly one data byte loads the segment register.
// - with bit 7 clear, 3-byte addresses use segment bits as the upper address.
// - dedicated commands always carry 4 address bytes regardless of the mode bit.
// - hardware reset, software reset and power cycle return to 3-byte addressing.
// - single-byte command F0h performs a software reset.
// - first status register mixes volatile and nonvolatile bits.
// - status writes need a preceding write enable 06h, else refused.
module fxa_ctrl #(
  parameter logic [5:0] SR_NV_INIT = fxa_pkg::SR_NV_RST
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  input  wire logic        hw_rst_n,
  output logic [7:0]       seg_value,
  output logic             addr4_mode,
  output logic [30:0]      mem_addr,
  output logic             mem_addr_valid,
  output logic [7:0]       status_reg,
  output logic             wrsr_refused
);
  fxa_link_if lif ();

  logic [2:0]          sync_q;
  logic                cs_s;
  logic                tgl_s;
  logic                hw_s;
  logic                cs_d_r;
  logic                tgl_d_r;
  logic                link_rst_r;
  logic                byte_ev;
  logic                frame_end;
  logic                any_rst;
  logic [7:0]          seg_r;
  logic                wel_r;
  logic [5:0]          nv_r;
  fxa_pkg::fxa_state_type state_r;
  fxa_pkg::fxa_op_type    op_r;
  logic [2:0]          need_r;
  logic [2:0]          got_r;
  logic [31:0]         addr_sh_r;
  logic                addr4_r;
  logic [7:0]          data_r;
  logic [1:0]          data_cnt_r;
  logic [2:0]          len_nxt;

  // number of address bytes a read command expects, zero for non-reads
  function automatic logic [2:0] addr_len(input logic [7:0] cmd, input logic mode4);
    logic [2:0] n;
    n = 3'h0;
    if (cmd == fxa_pkg::CMD_READ4)
      n = fxa_pkg::ADDR_LEN4;
    else if (cmd == fxa_pkg::CMD_READ3)
      n = mode4 ? fxa_pkg::ADDR_LEN4 : fxa_pkg::ADDR_LEN3;
    return n;
  endfunction

  fxa_link u_link (
    .spi_sck     (spi_sck),
    .spi_cs_n    (spi_cs_n),
    .spi_mosi    (spi_mosi),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .lif         (lif.link)
  );

  fxa_sync #(
    .W    (3),
    .INIT (fxa_pkg::SYNC_RST)
  ) u_sync (
    .clk  (sys_clk),
    .nrst (nrst),
    .d    ({spi_cs_n, lif.rx_tgl, hw_rst_n}),
    .q    (sync_q)
  );

  assign cs_s  = sync_q[2];
  assign tgl_s = sync_q[1];
  assign hw_s  = sync_q[0];

  assign lif.link_rst   = link_rst_r;
  assign lif.seg_mirror = seg_r;

  // link side held in reset while the system reset is asserted
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      link_rst_r <= 1'b1;
    else
      link_rst_r <= 1'b0;
  end

  // third stage for edges; deselect and toggle share one delay, so the deselect is seen after the last byte
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      cs_d_r  <= 1'b1;
      tgl_d_r <= 1'b0;
    end
    else
    begin
      cs_d_r  <= cs_s;
      tgl_d_r <= tgl_s;
    end
  end

  assign byte_ev   = tgl_s ^ tgl_d_r;
  assign frame_end = cs_s && !cs_d_r;
  assign any_rst   = !hw_s;
  assign len_nxt   = addr_len(lif.rx_byte, seg_r[fxa_pkg::SEG_MODE_BIT]);

  // command sequencing per frame
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || any_rst || frame_end)
    begin
      state_r    <= fxa_pkg::ST_CMD;
      op_r       <= fxa_pkg::OP_NONE;
      need_r     <= 3'h0;
      got_r      <= 3'h0;
      addr_sh_r  <= 32'h0000_0000;
      addr4_r    <= 1'b0;
      data_r     <= 8'h00;
      data_cnt_r <= 2'h0;
    end
    else if (byte_ev)
    begin
      unique case (state_r)
        fxa_pkg::ST_CMD:
        begin
          state_r <= fxa_pkg::ST_SKIP;
          if (len_nxt != 3'h0)
          begin
            state_r <= fxa_pkg::ST_ADDR;
            need_r  <= len_nxt;
            addr4_r <= (len_nxt == fxa_pkg::ADDR_LEN4);
          end
          else if (lif.rx_byte == fxa_pkg::CMD_WR_SEG)
          begin
            state_r <= fxa_pkg::ST_DATA;
            op_r    <= fxa_pkg::OP_WSEG;
          end
          else if (lif.rx_byte == fxa_pkg::CMD_WRSR)
          begin
            state_r <= fxa_pkg::ST_DATA;
            op_r    <= fxa_pkg::OP_WSR;
          end
          else if (lif.rx_byte == fxa_pkg::CMD_WREN)
            op_r <= fxa_pkg::OP_WREN;
          else if (lif.rx_byte == fxa_pkg::CMD_WRDI)
            op_r <= fxa_pkg::OP_WRDI;
          else if (lif.rx_byte == fxa_pkg::CMD_SOFT_RST)
            op_r <= fxa_pkg::OP_SRST;
        end
        fxa_pkg::ST_ADDR:
        begin
          addr_sh_r <= {addr_sh_r[23:0], lif.rx_byte};
          got_r     <= got_r + 3'h1;
          if (got_r + 3'h1 == need_r)
            state_r <= fxa_pkg::ST_SKIP;
        end
        fxa_pkg::ST_DATA:
        begin
          data_r <= lif.rx_byte;
          if (data_cnt_r != 2'h2)
            data_cnt_r <= data_cnt_r + 2'h1;
        end
        fxa_pkg::ST_SKIP:
        begin
          state_r <= fxa_pkg::ST_SKIP;
        end
      endcase
    end
  end

  // effective address issued once the last address byte is in
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      mem_addr       <= 31'h0000_0000;
      mem_addr_valid <= 1'b0;
    end
    else
    begin
      mem_addr_valid <= 1'b0;
      if (byte_ev && state_r == fxa_pkg::ST_ADDR && got_r + 3'h1 == need_r)
      begin
        mem_addr_valid <= 1'b1;
        if (addr4_r)
          mem_addr <= {addr_sh_r[22:0], lif.rx_byte};
        else
          mem_addr <= {seg_r[6:0], addr_sh_r[15:0], lif.rx_byte};
      end
    end
  end

  // segment register: any reset returns to segment 0 in 3-byte mode
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || any_rst)
      seg_r <= fxa_pkg::SEG_RST;
    else if (frame_end && op_r == fxa_pkg::OP_SRST)
      seg_r <= fxa_pkg::SEG_RST;
    else if (frame_end && op_r == fxa_pkg::OP_WSEG && data_cnt_r == 2'h1)
      seg_r <= data_r;
  end

  // write enable latch, the volatile part of the status register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || any_rst)
      wel_r <= 1'b0;
    else if (frame_end)
    begin
      unique case (op_r)
        fxa_pkg::OP_WREN: wel_r <= 1'b1;
        fxa_pkg::OP_WRDI: wel_r <= 1'b0;
        fxa_pkg::OP_SRST: wel_r <= 1'b0;
        fxa_pkg::OP_WSR:  wel_r <= 1'b0;
        fxa_pkg::OP_WSEG: wel_r <= wel_r;
        fxa_pkg::OP_NONE: wel_r <= wel_r;
        default:          wel_r <= wel_r;
      endcase
    end
  end

  // nonvolatile bits survive hardware and soft resets, nrst reloads SR_NV_INIT; a real part would back them with the array
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      nv_r         <= SR_NV_INIT;
      wrsr_refused <= 1'b0;
    end
    else
    begin
      wrsr_refused <= 1'b0;
      if (frame_end && op_r == fxa_pkg::OP_WSR && data_cnt_r != 2'h0)
      begin
        if (wel_r)
          nv_r <= data_r[7:fxa_pkg::SR_NV_LSB];
        else
          wrsr_refused <= 1'b1;
      end
    end
  end

  always_comb
  begin
    status_reg                      = {nv_r, 2'b00};
    status_reg[fxa_pkg::SR_WEL_BIT] = wel_r;
    status_reg[fxa_pkg::SR_WIP_BIT] = 1'b0;
  end

  assign seg_value  = seg_r;
  assign addr4_mode = seg_r[fxa_pkg::SEG_MODE_BIT];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  seg_hw_clear_a: assert property (any_rst |=> seg_r == 8'h00)
    else $error("segment not cleared by hardware reset");
  seg_soft_clear_a: assert property ((frame_end && op_r == fxa_pkg::OP_SRST && !any_rst) |=> seg_r == 8'h00)
    else $error("segment not cleared by soft reset");
  seg_load_a: assert property ((frame_end && op_r == fxa_pkg::OP_WSEG && data_cnt_r == 2'h1 && !any_rst)
      |=> seg_r == $past(data_r))
    else $error("segment write lost");
  seg_stable_a: assert property ((!frame_end && !any_rst) |=> $stable(seg_r))
    else $error("segment changed outside frame end");
  wsr_gate_a: assert property ((frame_end && op_r == fxa_pkg::OP_WSR && data_cnt_r != 2'h0 && !wel_r)
      |=> $stable(nv_r) && wrsr_refused)
    else $error("status write taken without enable");
  wsr_take_a: assert property ((frame_end && op_r == fxa_pkg::OP_WSR && data_cnt_r != 2'h0 && wel_r)
      |=> nv_r == $past(data_r[7:fxa_pkg::SR_NV_LSB]) && !wrsr_refused)
    else $error("enabled status write lost");
  wel_set_a: assert property ((frame_end && op_r == fxa_pkg::OP_WREN && !any_rst)
      |=> status_reg[fxa_pkg::SR_WEL_BIT])
    else $error("write enable not latched");
  wel_clear_a: assert property ((frame_end && (op_r == fxa_pkg::OP_WRDI || op_r == fxa_pkg::OP_WSR) && !any_rst)
      |=> !status_reg[fxa_pkg::SR_WEL_BIT])
    else $error("write enable not cleared");
  addr3_map_a: assert property ((mem_addr_valid && !addr4_r && $past(!any_rst)) |-> mem_addr[30:24] == seg_r[6:0])
    else $error("3-byte address ignores segment");
  addr_len_a: assert property ((byte_ev && state_r == fxa_pkg::ST_CMD && lif.rx_byte == fxa_pkg::CMD_READ3
      && seg_r[fxa_pkg::SEG_MODE_BIT] && !frame_end && !any_rst) |=> need_r == fxa_pkg::ADDR_LEN4)
    else $error("4-byte mode not honoured");
  addr3_len_a: assert property ((byte_ev && state_r == fxa_pkg::ST_CMD && lif.rx_byte == fxa_pkg::CMD_READ3
      && !seg_r[fxa_pkg::SEG_MODE_BIT] && !frame_end && !any_rst) |=> need_r == fxa_pkg::ADDR_LEN3)
    else $error("3-byte mode not honoured");
  read4_len_a: assert property ((byte_ev && state_r == fxa_pkg::ST_CMD && lif.rx_byte == fxa_pkg::CMD_READ4
      && !frame_end && !any_rst) |=> need_r == fxa_pkg::ADDR_LEN4)
    else $error("dedicated 4-byte read not honoured");
endmodule

// [verif/fxa_host.sv]
// serial host model driving the link side of the extended-address block
`timescale 1ns/100ps
module fxa_host (
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // quad read mode is never entered, so no exit sequence is owed before a reset
  // one command per frame, msb first; clock stands low outside frames
  task automatic frame(input logic [39:0] d, input int n, input real hp, output logic [7:0] rx);
    int i;
    spi_cs_n = 1'b0;
    for (i = 0; i < 8 * n; i++)
    begin
      spi_mosi = d[8*n-1-i];
      #(hp);
      spi_sck = 1'b1;
      rx = {rx[6:0], spi_miso};
      #(hp);
      spi_sck = 1'b0;
    end
    #(hp);
    spi_cs_n = 1'b1;
    // released line must not keep the last bit
    spi_mosi = ~spi_mosi;
    #40;
  endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the extended-address control block
`timescale 1ns/100ps
module tb;
  logic        sys_clk, nrst, hw_rst_n, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic        addr4_mode, mem_addr_valid, wrsr_refused;
  logic [7:0]  seg_value, status_reg, rx, v;
  logic [30:0] mem_addr, last_addr, exp_addr;
  logic [31:0] a;
  int          err_count, check_count, addr_cnt, ref_cnt, n_addr, n_ref, m_seg, m_nv, m_wel, k;
  int          oe_cnt, n_oe;
  integer      seed;

  always #2 sys_clk = ~sys_clk;

  fxa_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  fxa_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .hw_rst_n(hw_rst_n),
    .seg_value(seg_value), .addr4_mode(addr4_mode), .mem_addr(mem_addr),
    .mem_addr_valid(mem_addr_valid), .status_reg(status_reg), .wrsr_refused(wrsr_refused));

  // counting pulses also proves each one lasts a single cycle
  always @(posedge sys_clk)
  begin
    if (mem_addr_valid === 1'b1)
    begin
      last_addr <= mem_addr;
      addr_cnt <= addr_cnt + 1;
    end
    if (wrsr_refused === 1'b1)
      ref_cnt <= ref_cnt + 1;
  end

  // oe must stand for exactly the eight readback bits of a 16h frame
  always @(posedge spi_sck)
  begin
    if (spi_miso_oe === 1'b1)
      oe_cnt <= oe_cnt + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // link clock of 15 ns, its phase drifts against the system clock
  task automatic send(input logic [39:0] d, input int n);
    @(posedge sys_clk);
    #1;
    host.frame(d, n, 7.5, rx);
  endtask

  task automatic regs;
    repeat (12) @(posedge sys_clk);
    check(seg_value, m_seg);
    check(addr4_mode, m_seg >> 7);
    check(status_reg, {m_nv[5:0], m_wel[0], 1'b0});
    check(addr_cnt, n_addr);
    check(ref_cnt, n_ref);
    check(oe_cnt, n_oe);
    check(spi_miso_oe, 1'b0);
  endtask

  task automatic put_seg;
    v = 8'($random(seed));
    v[7] = k[0];
    send({fxa_pkg::CMD_WR_SEG, v}, 2);
    m_seg = v;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    hw_rst_n = 1'b1;
    seed = 32'h9d2f;
    {err_count, check_count, addr_cnt, ref_cnt, n_addr, n_ref, m_seg, m_nv, m_wel} = '0;
    {oe_cnt, n_oe} = '0;
    repeat (10) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (6) @(posedge sys_clk);
    regs;
    for (k = 0; k < 4; k++)
    begin
      put_seg;
      regs;
      send({fxa_pkg::CMD_RD_SEG, 8'h00}, 2);
      n_oe += 8;
      check(rx, m_seg);
      a = $random(seed);
      if (m_seg[7])
      begin
        send({fxa_pkg::CMD_READ3, a}, 5);
        exp_addr = a[30:0];
      end
      else
      begin
        send({fxa_pkg::CMD_READ3, a[23:0]}, 4);
        exp_addr = {m_seg[6:0], a[23:0]};
      end
      n_addr++;
      regs;
      check(last_addr, exp_addr);
      send({fxa_pkg::CMD_READ4, a}, 5);
      n_addr++;
      regs;
      check(last_addr, a[30:0]);
    end
    v = 8'($random(seed));
    send({fxa_pkg::CMD_WR_SEG, v, v}, 3);
    send({32'h0, fxa_pkg::CMD_WR_SEG}, 1);
    regs;
    for (k = 0; k < 3; k++)
    begin
      if (k > 0)
        send({32'h0, fxa_pkg::CMD_WREN}, 1);
      if (k == 2)
        send({32'h0, fxa_pkg::CMD_WRDI}, 1);
      v = 8'($random(seed));
      send({fxa_pkg::CMD_WRSR, v}, 2);
      if (k == 1)
        m_nv = v[7:2];
      else
        n_ref++;
      regs;
    end
    k = 1;
    put_seg;
    send({32'h0, fxa_pkg::CMD_WREN}, 1);
    m_wel = 1;
    regs;
    send({32'h0, fxa_pkg::CMD_SOFT_RST}, 1);
    {m_seg, m_wel} = '0;
    regs;
    put_seg;
    send({32'h0, fxa_pkg::CMD_WREN}, 1);
    @(posedge sys_clk);
    #1 hw_rst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 hw_rst_n = 1'b1;
    {m_seg, m_wel} = '0;
    regs;
    put_seg;
    @(posedge sys_clk);
    #1 nrst = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 nrst = 1'b1;
    {m_seg, m_nv, m_wel} = '0;
    regs;
    end_of_test;
  end

  initial
  begin
    #200000;
    err_count++;
    end_of_test;
  end
endmodule
